// ==== dv/tb_top.sv ====
// Self-checking testbench of the endpoint configuration block.
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] A0 = uec_pkg::ADDR_EP_CFG_BASE;
  localparam logic [31:0] A1 = A0 + uec_pkg::ADDR_EP_CFG_STRIDE;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, brst = 1'b0, send = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [31:0] adr = 32'h0, dat = 32'h0, dato, rd;
  logic [1:0] pid = 2'h0;
  logic [2:0] ep = 3'h0;
  logic ack, err, nak, e;
  uec_pkg::uec_token_s tok;
  uec_pkg::uec_attr_s [uec_pkg::NUM_EP-1:0] attr;
  int bad_count = 0, comparisons = 0;
  always #2.5 clk = ~clk;
  uec_top uut (.CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack), .WB_ERR_O(err),
    .USB_BUS_RESET(brst), .TOKEN(tok), .EP_ATTR(attr), .TOKEN_NAK(nak));
  uec_host_model host (.CLK_SYS(clk), .RST(rst), .send(send), .pid(pid), .ep(ep), .tok(tok));
  task automatic chk(input logic [31:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle; the request is held until ack or err is sampled, then idles a cycle.
  // The wait has no limit of its own, so a slave that never answers is caught by the watchdog.
  task automatic wb(input logic w, input logic [31:0] a, d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    rd = dato;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Asks the host for a token; returns when its nak answer can be sampled.
  task automatic tk(input logic [1:0] p, input logic [2:0] x);
    send <= 1'b1;
    pid <= p;
    ep <= x;
    @(posedge clk);
    send <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, A0 + i * uec_pkg::ADDR_EP_CFG_STRIDE, 32'h0);
      chk(rd, 32'h0, "reset cfg");
    end
    wb(1'b0, 32'hf803c104, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped err");
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, A1, {26'h0, 2'h1, 1'b1, c[2:0]});
      chk({21'h0, attr[1].max_packet_bytes}, 32'h8 << c, "max packet");
      chk({31'h0, attr[1].dir_in}, 32'h1, "dir in");
      wb(1'b0, A1, 32'h0);
      chk(rd, {26'h0, 2'h1, 1'b1, c[2:0]}, "readback");
    end
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, A1, {26'h0, k[1:0], 4'h7});
      chk({30'h0, attr[1].endpoint_kind}, k, "kind");
      chk({21'h0, attr[1].max_packet_bytes}, k == 1 ? 32'h400 : 32'h200, "clamp");
      chk({31'h0, attr[1].dir_in}, 32'h0, "dir out");
      wb(1'b0, A1, 32'h0);
      chk(rd, {26'h0, k[1:0], 1'b0, k == 1 ? 3'h7 : 3'h6}, "stored");
    end
    $display("test decode done");
    // Endpoint 0 as control, direction bit set on purpose; it must not matter.
    wb(1'b1, A0, 32'h8);
    chk({31'h0, attr[0].dir_in}, 32'h0, "ctrl dir ignored");
    for (int t = 0; t < 4; t++) begin
      tk(t == 0 ? 2'h1 : (t == 1 ? 2'h2 : 2'h3), 3'h0);
      chk({31'h0, nak}, t == 2, "nak");
    end
    tk(2'h1, 3'h0);
    tk(2'h2, 3'h0);
    tk(2'h3, 3'h1);
    chk({31'h0, nak}, 32'h0, "nak other ep");
    tk(2'h3, 3'h0);
    chk({31'h0, nak}, 32'h1, "nak restart");
    // Endpoint 1 was refused a 1024-byte size and a NAK went out, so both sticky bits stand.
    wb(1'b0, uec_pkg::ADDR_EP_STAT, 32'h0);
    chk(rd, 32'h102, "status sticky");
    wb(1'b1, uec_pkg::ADDR_EP_STAT, 32'h1ff);
    wb(1'b0, uec_pkg::ADDR_EP_STAT, 32'h0);
    chk(rd, 32'h0, "status cleared");
    $display("test control done");
    brst <= 1'b1;
    repeat (6) @(posedge clk);
    brst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(attr[1], {11'h008, 1'b0, 2'h0}, "cleared attr");
    chk(attr[0], {11'h008, 1'b0, 2'h0}, "cleared attr0");
    wb(1'b0, A1, 32'h0);
    chk(rd, 32'h0, "cleared cfg");
    $display("test bus reset done");
    final_report;
  end
  // Cuts a hang short well beyond the roughly 150 cycles the tests need.
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    final_report;
  end
endmodule

// ==== dv/uec_host_model.sv ====
// Host side model that turns a request into a one-cycle token.
`timescale 1ns/1ps
module uec_host_model (
  input  wire logic          CLK_SYS,
  input  wire logic          RST,
  input  wire logic          send,
  input  wire logic [1:0]    pid,
  input  wire logic [2:0]    ep,
  output uec_pkg::uec_token_s tok
);
  uec_pkg::uec_token_s tok_d;
  // Idle tokens invert the endpoint so nothing can lean on a stale number.
  always_comb begin
    tok_d = '{1'b0, ~tok.ep, 1'b0, 1'b0, 1'b0};
    if (send) begin
      tok_d = '{1'b1, ep, pid == 2'h1, pid == 2'h2, pid == 2'h3};
    end
  end
  // One token per request, standing for exactly one cycle.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tok <= '0;
    end else begin
      tok <= tok_d;
    end
  end
endmodule

// ==== dv/uec_top_checker.sv ====
// Concurrent checks on the ports of the endpoint configuration block.
`timescale 1ns/1ps
module uec_top_checker (
  input wire logic                                CLK_SYS,
  input wire logic                                RST,
  input wire logic                                WB_CYC_I,
  input wire logic                                WB_STB_I,
  input wire logic                                WB_WE_I,
  input wire logic [31:0]                         WB_ADR_I,
  input wire logic [3:0]                          WB_SEL_I,
  input wire logic [31:0]                         WB_DAT_I,
  input wire logic [31:0]                         WB_DAT_O,
  input wire logic                                WB_ACK_O,
  input wire logic                                WB_ERR_O,
  input wire logic                                USB_BUS_RESET,
  input wire uec_pkg::uec_token_s                 TOKEN,
  input wire uec_pkg::uec_attr_s [uec_pkg::NUM_EP-1:0] EP_ATTR,
  input wire logic                                TOKEN_NAK
);
  localparam logic [31:0] EP1 = uec_pkg::ADDR_EP_CFG_BASE + uec_pkg::ADDR_EP_CFG_STRIDE;
  localparam uec_pkg::uec_attr_s CLR = '{11'h008, 1'b0, uec_pkg::KIND_CONTROL};
  logic wr1;
  // A completed write to endpoint 1; data is still held at the acknowledging edge.
  assign wr1 = WB_ACK_O && WB_WE_I && (WB_ADR_I == EP1) && WB_SEL_I[0];
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_size_decode: assert property (
    wr1 && WB_DAT_I[5:4] == 2'h1 |-> EP_ATTR[1].max_packet_bytes == (11'h008 << WB_DAT_I[2:0]))
    else $error("size code decoded to wrong packet size");
  a_size_clamp: assert property (
    wr1 && WB_DAT_I[2:0] == 3'h7 && WB_DAT_I[5:4] != 2'h1 |-> EP_ATTR[1].max_packet_bytes == 11'h200)
    else $error("non isochronous endpoint allowed above 512 bytes");
  a_dir_decode: assert property (
    wr1 && WB_DAT_I[5:4] != 2'h0 |-> EP_ATTR[1].dir_in == WB_DAT_I[3])
    else $error("direction bit decoded wrongly");
  a_ctrl_dir_ignored: assert property (
    EP_ATTR[0].endpoint_kind == uec_pkg::KIND_CONTROL |-> !EP_ATTR[0].dir_in)
    else $error("control endpoint took its direction bit");
  a_kind_decode: assert property (
    wr1 |-> EP_ATTR[1].endpoint_kind == WB_DAT_I[5:4])
    else $error("endpoint kind decoded wrongly");
  a_bus_reset_clear: assert property (
    USB_BUS_RESET [*4] |-> EP_ATTR[0] == CLR && EP_ATTR[1] == CLR)
    else $error("bus reset left configuration set");
  a_nak_cause: assert property (
    TOKEN_NAK |-> $past(TOKEN.valid && TOKEN.is_out))
    else $error("nak without a preceding out token");
  a_nak_pulse: assert property (
    TOKEN_NAK |=> !TOKEN_NAK)
    else $error("nak longer than one cycle");
  a_read_back: assert property (
    WB_ACK_O && !WB_WE_I && WB_ADR_I == EP1 |-> WB_DAT_O[31:6] == 26'h0 && WB_DAT_O[5:4] == EP_ATTR[1].endpoint_kind)
    else $error("read data disagrees with configuration");
  a_ack_cause: assert property (
    WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I) && !WB_ERR_O)
    else $error("ack without a request");
  // Main scenarios reached.
  cover property (wr1 && WB_DAT_I[5:4] == 2'h1 && WB_DAT_I[2:0] == 3'h7);
  cover property (TOKEN_NAK);
  cover property (WB_ERR_O);
endmodule
bind uec_top uec_top_checker u_chk (.*);

// ==== hw/uec_ctl_track.sv ====
// Control transfer tracker that forces NAK on the first status OUT token.
`timescale 1ns/1ps
module uec_ctl_track (
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  input  wire logic                bus_reset,
  input  wire uec_pkg::uec_token_s tok,
  input  wire logic                is_control,
  output logic                     force_nak
);

  uec_pkg::uec_ctl_e state_q;
  uec_pkg::uec_ctl_e state_d;
  logic              nak_q;
  logic              nak_d;

  // A SETUP restarts the sequence; an IN after it marks a data IN stage, and the
  // first OUT after that stage is the status token that gets NAK exactly once.
  always_comb begin
    state_d = state_q;
    nak_d   = 1'b0;
    if (bus_reset) begin
      state_d = uec_pkg::CT_IDLE;
    end else if (tok.valid && is_control) begin
      if (tok.is_setup) begin
        state_d = uec_pkg::CT_IDLE;
      end else begin
        case (state_q)
          uec_pkg::CT_IDLE: begin
            if (tok.is_in) begin
              state_d = uec_pkg::CT_DATA_IN;
            end
          end
          uec_pkg::CT_DATA_IN: begin
            if (tok.is_out) begin
              nak_d   = 1'b1; // [RULE_07]
              state_d = uec_pkg::CT_STATUS;
            end
          end
          uec_pkg::CT_STATUS: begin
            state_d = uec_pkg::CT_STATUS;
          end
          default: begin
            state_d = uec_pkg::CT_IDLE;
          end
        endcase
      end
    end
  end

  // State registers.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= uec_pkg::CT_IDLE;
      nak_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      nak_q   <= nak_d;
    end
  end

  assign force_nak = nak_q;

endmodule

// ==== hw/uec_pkg.sv ====
// Package of constants and types for the USB endpoint configuration block.
package uec_pkg;

  localparam int unsigned NUM_EP = 7;

  // Register map: one word per endpoint, stride of 0x20 bytes from the base.
  localparam logic [31:0] ADDR_EP_CFG_BASE   = 32'hf803c100;
  localparam logic [31:0] ADDR_EP_CFG_STRIDE = 32'h00000020;
  localparam logic [31:0] ADDR_EP_STAT       = 32'hf803c0f0;

  // Field layout of an endpoint configuration word.
  localparam int unsigned SIZE_LSB = 0;
  localparam int unsigned SIZE_W   = 3;
  localparam int unsigned DIR_BIT  = 3;
  localparam int unsigned KIND_LSB = 4;
  localparam int unsigned KIND_W   = 2;

  // Status word layout.
  localparam int unsigned STAT_REJ_LSB = 0;
  localparam int unsigned STAT_NAK_LSB = 8;

  localparam logic [2:0]  SIZE_RESET    = 3'h0;
  localparam logic        DIR_RESET     = 1'h0;
  localparam logic [2:0]  SIZE_CODE_MAX_NONISO = 3'h6;
  localparam logic [10:0] SIZE_BASE_BYTES      = 11'h008;

  typedef enum logic [1:0] {
    KIND_CONTROL   = 2'h0,
    KIND_ISO       = 2'h1,
    KIND_BULK      = 2'h2,
    KIND_INTERRUPT = 2'h3
  } uec_kind_e;

  // Decoded configuration of one endpoint.
  typedef struct packed {
    logic [2:0]  endpoint_size_code;
    logic        endpoint_direction;
    uec_kind_e   endpoint_kind;
  } uec_cfg_s;

  // Decoded attributes that the packet engine consumes.
  typedef struct packed {
    logic [10:0] max_packet_bytes;
    logic        dir_in;
    uec_kind_e   endpoint_kind;
  } uec_attr_s;

  // Token from the packet engine.
  typedef struct packed {
    logic       valid;
    logic [2:0] ep;
    logic       is_setup;
    logic       is_in;
    logic       is_out;
  } uec_token_s;

  // Control transfer phase tracking, one-hot.
  typedef enum logic [2:0] {
    CT_IDLE    = 3'b001,
    CT_DATA_IN = 3'b010,
    CT_STATUS  = 3'b100
  } uec_ctl_e;

endpackage

// ==== hw/uec_top.sv ====
// Endpoint configuration registers of a high-speed USB device port with Wishbone access.
// Summary of operation
// [RULE_01] Size code 0..7 selects a maximum packet of 8, 16, 32, 64, 128, 256, 512 or 1024 bytes.
// [RULE_02] The 1024-byte code is accepted only for isochronous endpoints; others are held to 512 or less.
// [RULE_03] For bulk, interrupt and isochronous endpoints direction 0 means OUT and 1 means IN.
// [RULE_04] A control endpoint ignores its direction bit, which software should leave at zero.
// [RULE_05] Kind 0 is control, 1 isochronous and 2 bulk.
// [RULE_06] A USB bus reset clears size, direction and kind of every endpoint.
// [RULE_07] After a control data IN stage the first status OUT token is answered with NAK.
// [RULE_08] Software sets endpoint 0 to control; kind 3 selects an interrupt endpoint.
// [RULE_09] A configuration read returns the last written fields, or their cleared values after bus reset.
`timescale 1ns/1ps
module uec_top (
  input  wire logic                                  CLK_SYS,
  input  wire logic                                  RST,
  input  wire logic                                  WB_CYC_I,
  input  wire logic                                  WB_STB_I,
  input  wire logic                                  WB_WE_I,
  input  wire logic [31:0]                           WB_ADR_I,
  input  wire logic [3:0]                            WB_SEL_I,
  input  wire logic [31:0]                           WB_DAT_I,
  output logic      [31:0]                           WB_DAT_O,
  output logic                                       WB_ACK_O,
  output logic                                       WB_ERR_O,
  input  wire logic                                  USB_BUS_RESET,
  input  wire uec_pkg::uec_token_s                   TOKEN,
  output uec_pkg::uec_attr_s [uec_pkg::NUM_EP-1:0]   EP_ATTR,
  output logic                                       TOKEN_NAK
);

  uec_pkg::uec_cfg_s [uec_pkg::NUM_EP-1:0] cfg_q;
  uec_pkg::uec_cfg_s [uec_pkg::NUM_EP-1:0] cfg_d;
  logic [uec_pkg::NUM_EP-1:0]              rej_q;
  logic [uec_pkg::NUM_EP-1:0]              rej_d;
  logic [31:0]                             rdata_q;
  logic [31:0]                             rdata_d;
  logic                                    ack_q;
  logic                                    ack_d;
  logic                                    err_q;
  logic                                    err_d;
  logic                                    nak_seen_q;
  logic                                    nak_seen_d;
  logic                                    bus_rst_s1_q;
  logic                                    bus_rst_s2_q;
  logic                                    req;
  logic [31:0]                             offs;
  logic [2:0]                              ep_idx;
  logic                                    hit_cfg;
  logic                                    hit_stat;
  logic                                    ctl_is_control;
  logic                                    force_nak;

  // The bus reset comes from the line-state detector in another domain, so it
  // passes two flops before anything else looks at it.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bus_rst_s1_q <= 1'b0;
      bus_rst_s2_q <= 1'b0;
    end else begin
      bus_rst_s1_q <= USB_BUS_RESET;
      bus_rst_s2_q <= bus_rst_s1_q;
    end
  end

  // Address decode; a new request is taken only while no answer is pending.
  assign req      = WB_CYC_I && WB_STB_I && !ack_q && !err_q;
  assign offs     = WB_ADR_I - uec_pkg::ADDR_EP_CFG_BASE;
  assign ep_idx   = offs[7:5];
  assign hit_cfg  = (WB_ADR_I >= uec_pkg::ADDR_EP_CFG_BASE) && (offs[31:8] == 24'h000000)
                    && (offs[4:0] == 5'h00) && (ep_idx < 3'(uec_pkg::NUM_EP));
  assign hit_stat = (WB_ADR_I == uec_pkg::ADDR_EP_STAT);

  // Register writes, bus-reset clearing and the one-cycle bus answer.
  // Only byte lane 0 holds configuration bits, so only SEL[0] gates the write.
  always_comb begin
    cfg_d      = cfg_q;
    rej_d      = rej_q;
    rdata_d    = rdata_q;
    ack_d      = 1'b0;
    err_d      = 1'b0;
    nak_seen_d = nak_seen_q | force_nak;
    if (req) begin
      ack_d = hit_cfg || hit_stat;
      err_d = !(hit_cfg || hit_stat);
      if (hit_cfg && WB_WE_I && WB_SEL_I[0]) begin
        cfg_d[ep_idx].endpoint_size_code = WB_DAT_I[uec_pkg::SIZE_LSB +: uec_pkg::SIZE_W];
        cfg_d[ep_idx].endpoint_direction = WB_DAT_I[uec_pkg::DIR_BIT];
        cfg_d[ep_idx].endpoint_kind      =
          uec_pkg::uec_kind_e'(WB_DAT_I[uec_pkg::KIND_LSB +: uec_pkg::KIND_W]); // [RULE_05]
        // A 1024-byte code on a non-isochronous kind is refused and clamped.
        if (WB_DAT_I[uec_pkg::SIZE_LSB +: uec_pkg::SIZE_W] > uec_pkg::SIZE_CODE_MAX_NONISO
            && uec_pkg::uec_kind_e'(WB_DAT_I[uec_pkg::KIND_LSB +: uec_pkg::KIND_W]) != uec_pkg::KIND_ISO) begin
          cfg_d[ep_idx].endpoint_size_code = uec_pkg::SIZE_CODE_MAX_NONISO; // [RULE_02]
          rej_d[ep_idx] = 1'b1;
        end
      end
      if (hit_stat && WB_WE_I && WB_SEL_I[0]) begin
        rej_d = rej_q & ~WB_DAT_I[uec_pkg::STAT_REJ_LSB +: uec_pkg::NUM_EP];
      end
      if (hit_stat && WB_WE_I && WB_SEL_I[1] && WB_DAT_I[uec_pkg::STAT_NAK_LSB]) begin
        nak_seen_d = force_nak; // A NAK arriving with the clear still wins.
      end
      rdata_d = 32'h00000000;
      if (hit_cfg && !WB_WE_I) begin
        rdata_d[uec_pkg::SIZE_LSB +: uec_pkg::SIZE_W] = cfg_q[ep_idx].endpoint_size_code; // [RULE_09]
        rdata_d[uec_pkg::DIR_BIT]                     = cfg_q[ep_idx].endpoint_direction;
        rdata_d[uec_pkg::KIND_LSB +: uec_pkg::KIND_W] = cfg_q[ep_idx].endpoint_kind;
      end
      if (hit_stat && !WB_WE_I) begin
        rdata_d[uec_pkg::STAT_REJ_LSB +: uec_pkg::NUM_EP] = rej_q;
        rdata_d[uec_pkg::STAT_NAK_LSB]                    = nak_seen_q;
      end
    end
    if (bus_rst_s2_q) begin
      for (int i = 0; i < uec_pkg::NUM_EP; i++) begin
        cfg_d[i].endpoint_size_code = uec_pkg::SIZE_RESET; // [RULE_06]
        cfg_d[i].endpoint_direction = uec_pkg::DIR_RESET;
        cfg_d[i].endpoint_kind      = uec_pkg::KIND_CONTROL;
      end
    end
  end

  // Register stage of the configuration and bus answer.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cfg_q      <= '0;
      rej_q      <= '0;
      rdata_q    <= 32'h00000000;
      ack_q      <= 1'b0;
      err_q      <= 1'b0;
      nak_seen_q <= 1'b0;
    end else begin
      cfg_q      <= cfg_d;
      rej_q      <= rej_d;
      rdata_q    <= rdata_d;
      ack_q      <= ack_d;
      err_q      <= err_d;
      nak_seen_q <= nak_seen_d;
    end
  end

  assign WB_DAT_O  = rdata_q;
  assign WB_ACK_O  = ack_q;
  assign WB_ERR_O  = err_q;
  assign TOKEN_NAK = force_nak;

  // Per-endpoint decode of packet size and direction for the packet engine.
  genvar g;
  generate
    for (g = 0; g < uec_pkg::NUM_EP; g++) begin : g_attr
      assign EP_ATTR[g].max_packet_bytes = uec_pkg::SIZE_BASE_BYTES << cfg_q[g].endpoint_size_code; // [RULE_01]
      // Control endpoints ignore the direction bit entirely.
      assign EP_ATTR[g].dir_in = (cfg_q[g].endpoint_kind != uec_pkg::KIND_CONTROL)
                                 && cfg_q[g].endpoint_direction; // [RULE_03] [RULE_04]
      assign EP_ATTR[g].endpoint_kind = cfg_q[g].endpoint_kind;
    end
  endgenerate

  assign ctl_is_control = (TOKEN.ep < 3'(uec_pkg::NUM_EP))
                          && (cfg_q[TOKEN.ep].endpoint_kind == uec_pkg::KIND_CONTROL);

  // Status-stage NAK tracker for control endpoints.
  uec_ctl_track u_ctl (
    .CLK_SYS    (CLK_SYS),
    .RST        (RST),
    .bus_reset  (bus_rst_s2_q),
    .tok        (TOKEN),
    .is_control (ctl_is_control),
    .force_nak  (force_nak)
  );

endmodule
